// [adcc_top.sv]
/*
 * Conversion control: register port, clock divider, conversion sequencer,
 * input and reference routing, and analog pin override.
 * Assumes the analog core presents its result on core_result at the last tick.
 */
`timescale 1ns/1ps
module adcc_top (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic arst_n,
	// Register port.
	input wire logic [adcc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [adcc_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [adcc_pkg::DATA_W-1:0] reg_rdata,
	// Analog core.
	input wire logic [adcc_pkg::RES_W-1:0] core_result,
	output adcc_pkg::adcc_core_ctl_t core_ctl,
	// Pad control.
	input wire logic [adcc_pkg::NUM_CH-1:0] gpio_oe,
	input wire logic [adcc_pkg::NUM_CH-1:0] gpio_pull_en,
	output adcc_pkg::adcc_pad_ctl_t pad_ctl,
	// Interrupt request to the system interrupt controller.
	output logic conv_irq_req
);
	import adcc_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} adcc_state_t;

	function automatic logic [6:0] div_last(input logic [2:0] sel);
		div_last = 7'((8'h01 << sel) - 8'h01);
	endfunction : div_last

	logic rst_s1_reg;
	logic rst_n;
	adcc_ctrl_a_t ctrl_a_reg, ctrl_a_next;
	adcc_ctrl_b_t ctrl_b_reg, ctrl_b_next;
	logic [NUM_CH-1:0] pin_sel_reg, pin_sel_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	adcc_state_t state_reg, state_next;
	logic [6:0] div_cnt_reg, div_cnt_next;
	logic [4:0] phase_reg, phase_next;
	logic armed_reg, armed_next;
	logic irq_reg, irq_next;
	logic [RES_W-1:0] result_reg, result_next;
	logic tick;
	logic busy;
	logic launch;
	logic abort;
	logic done;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n <= rst_s1_reg;
		end
	end

	assign busy = (state_reg != ST_IDLE);
	assign tick = busy && (div_cnt_reg == div_last(ctrl_b_reg.clk_div));
	assign abort = busy && (!ctrl_a_reg.power_en || ctrl_a_reg.start);
	assign launch = armed_reg && !ctrl_a_reg.start && ctrl_a_reg.power_en && !busy;
	assign done = (state_reg == ST_CONVERT) && tick && (phase_reg == CONV_TICKS - 5'h01) && !abort;

	// Register file.
	always_comb begin
		ctrl_a_next = ctrl_a_reg;
		ctrl_b_next = ctrl_b_reg;
		pin_sel_next = pin_sel_reg;
		rdata_next = '0;
		if (reg_wr) begin
			unique case (reg_addr)
				OFS_CTRL_A: begin
					ctrl_a_next = adcc_ctrl_a_t'(reg_wdata);
					ctrl_a_next.busy = 1'b0;
				end
				OFS_CTRL_B: ctrl_b_next = adcc_ctrl_b_t'(reg_wdata);
				OFS_PIN_SEL: pin_sel_next = reg_wdata;
				default: ;
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				OFS_CTRL_A: begin
					rdata_next = ctrl_a_reg;
					rdata_next[6] = busy;
				end
				OFS_CTRL_B: rdata_next = ctrl_b_reg;
				OFS_RES_HI: begin
					rdata_next = ctrl_a_reg.data_format ? {4'h0, result_reg[11:8]} : result_reg[11:4];
				end
				OFS_RES_LO: begin
					rdata_next = ctrl_a_reg.data_format ? result_reg[7:0] : {result_reg[3:0], 4'h0};
				end
				OFS_PIN_SEL: rdata_next = pin_sel_reg;
				default: rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_a_reg <= CTRL_A_RST;
			ctrl_b_reg <= CTRL_B_RST;
			pin_sel_reg <= PIN_SEL_RST;
			rdata_reg <= '0;
		end else begin
			ctrl_a_reg <= ctrl_a_next;
			ctrl_b_reg <= ctrl_b_next;
			pin_sel_reg <= pin_sel_next;
			rdata_reg <= rdata_next;
		end
	end

	// Conversion sequencer. Writing start high while busy aborts the conversion; a new one launches once start is written low.
	always_comb begin
		state_next = state_reg;
		div_cnt_next = '0;
		phase_next = phase_reg;
		armed_next = ctrl_a_reg.start;
		irq_next = 1'b0;
		result_next = result_reg;
		if (busy && !tick) begin
			div_cnt_next = 7'(div_cnt_reg + 7'h01);
		end
		unique case (state_reg)
			ST_IDLE: begin
				phase_next = '0;
				if (launch) begin
					state_next = ST_SAMPLE;
				end
			end
			ST_SAMPLE: begin
				if (tick) begin
					if (phase_reg == SAMPLE_TICKS - 5'h01) begin
						state_next = ST_CONVERT;
						phase_next = '0;
					end else begin
						phase_next = 5'(phase_reg + 5'h01);
					end
				end
			end
			ST_CONVERT: begin
				if (done) begin
					state_next = ST_IDLE;
					irq_next = 1'b1;
					result_next = core_result;
				end else if (tick) begin
					phase_next = 5'(phase_reg + 5'h01);
				end
			end
		endcase
		if (abort) begin
			state_next = ST_IDLE;
			irq_next = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			div_cnt_reg <= '0;
			phase_reg <= '0;
			armed_reg <= 1'b0;
			irq_reg <= 1'b0;
			result_reg <= '0;
		end else begin
			state_reg <= state_next;
			div_cnt_reg <= div_cnt_next;
			phase_reg <= phase_next;
			armed_reg <= armed_next;
			irq_reg <= irq_next;
			result_reg <= result_next;
		end
	end

	// Routing to the analog core and pin override.
	always_comb begin
		core_ctl = '0;
		core_ctl.power_en = ctrl_a_reg.power_en;
		core_ctl.ref_supply = (ctrl_b_reg.ref_sel == REF_SUPPLY_CODE);
		core_ctl.sample = (state_reg == ST_SAMPLE);
		core_ctl.convert = (state_reg == ST_CONVERT);
		core_ctl.conv_tick = tick;
		if (!ctrl_a_reg.ext_chan[3]) begin
			core_ctl.ext_chan_en[ctrl_a_reg.ext_chan[2:0]] = 1'b1;
		end else begin
			unique case (ctrl_b_reg.in_sel)
				INSEL_BGAP: core_ctl.int_src_en[0] = 1'b1;
				INSEL_AMP0: core_ctl.int_src_en[1] = 1'b1;
				INSEL_AMP1: core_ctl.int_src_en[2] = 1'b1;
				INSEL_PLT: core_ctl.int_src_en[3] = 1'b1;
				default: ;
			endcase
		end
		pad_ctl.oe = gpio_oe & ~pin_sel_reg;
		pad_ctl.pull_en = gpio_pull_en & ~pin_sel_reg;
		pad_ctl.dig_in_en = ~pin_sel_reg;
	end

	assign reg_rdata = rdata_reg;
	assign conv_irq_req = irq_reg;

	// Helper counters for the checks below.
	logic [11:0] busy_len_reg;
	logic [7:0] div_at_launch_reg;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_len_reg <= '0;
			div_at_launch_reg <= '0;
		end else begin
			busy_len_reg <= busy ? 12'(busy_len_reg + 12'h001) : 12'h000;
			if (launch) begin
				div_at_launch_reg <= 8'(div_last(ctrl_b_reg.clk_div)) + 8'h01;
			end
		end
	end

	a_busy_after_launch: assert property (@(posedge core_clk) disable iff (!rst_n)
		launch |=> busy) else $error("busy not set after launch");
	a_busy_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
		(busy && !abort && !done) |=> busy) else $error("busy dropped early");
	a_done_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
		done |=> (!busy && conv_irq_req)) else $error("busy not cleared at end");
	a_irq_at_end: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(conv_irq_req) |-> ($fell(busy) && !$past(abort))) else $error("stray request");
	a_conv_length: assert property (@(posedge core_clk) disable iff (!rst_n)
		(conv_irq_req && $fell(busy)) |-> (busy_len_reg == 12'(16 * div_at_launch_reg)))
		else $error("conversion length wrong");
	a_div_full_rate: assert property (@(posedge core_clk) disable iff (!rst_n)
		(busy && ctrl_b_reg.clk_div == 3'h0) |-> tick) else $error("undivided clock missed tick");
	a_sample_phase: assert property (@(posedge core_clk)
		disable iff (!rst_n || !ctrl_a_reg.power_en || ctrl_a_reg.start)
		(launch && ctrl_b_reg.clk_div == 3'h0) |=> core_ctl.sample [*4] ##1 core_ctl.convert)
		else $error("sampling phase length wrong");
	a_result_loaded: assert property (@(posedge core_clk) disable iff (!rst_n)
		conv_irq_req |-> (result_reg == $past(core_result))) else $error("result not loaded");
	a_abort_power: assert property (@(posedge core_clk) disable iff (!rst_n)
		(busy && !ctrl_a_reg.power_en) |=> (!busy && !conv_irq_req)) else $error("abort failed");
	a_no_launch_off: assert property (@(posedge core_clk) disable iff (!rst_n)
		(!busy && !ctrl_a_reg.power_en) |=> !busy) else $error("launch while off");
	a_ref_route: assert property (@(posedge core_clk) disable iff (!rst_n)
		core_ctl.ref_supply |-> (ctrl_b_reg.ref_sel == 2'h1)) else $error("reference misrouted");
	a_no_short: assert property (@(posedge core_clk) disable iff (!rst_n)
		(core_ctl.int_src_en != '0) |-> (core_ctl.ext_chan_en == '0)) else $error("source short");
	a_pin_override: assert property (@(posedge core_clk) disable iff (!rst_n)
		((pad_ctl.oe | pad_ctl.pull_en) & pin_sel_reg) == '0) else $error("analog pin driven");

	c_launch: cover property (@(posedge core_clk) disable iff (!rst_n) launch);
	c_done: cover property (@(posedge core_clk) disable iff (!rst_n) done);
	c_abort: cover property (@(posedge core_clk) disable iff (!rst_n) abort);
	c_internal: cover property (@(posedge core_clk) disable iff (!rst_n) done && core_ctl.int_src_en != '0);
endmodule : adcc_top

// [adcc_pkg.sv]
/*
 * Constants, field layouts and carrier types for the conversion control block.
 * Assumes one 40 MHz system clock and a same-clock analog core and pad logic.
 */
package adcc_pkg;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam int RES_W = 12;
	localparam int NUM_CH = 8;
	localparam int NUM_INT = 4;
	localparam int CLK_PERIOD_NS = 25;
	localparam logic [ADDR_W-1:0] OFS_CTRL_A = 3'h0;
	localparam logic [ADDR_W-1:0] OFS_CTRL_B = 3'h1;
	localparam logic [ADDR_W-1:0] OFS_RES_HI = 3'h2;
	localparam logic [ADDR_W-1:0] OFS_RES_LO = 3'h3;
	localparam logic [ADDR_W-1:0] OFS_PIN_SEL = 3'h4;
	localparam logic [DATA_W-1:0] CTRL_A_RST = 8'h00;
	localparam logic [DATA_W-1:0] CTRL_B_RST = 8'h00;
	localparam logic [DATA_W-1:0] PIN_SEL_RST = 8'h00;
	localparam logic [1:0] REF_SUPPLY_CODE = 2'h1;
	localparam logic [2:0] INSEL_BGAP = 3'h1;
	localparam logic [2:0] INSEL_AMP0 = 3'h2;
	localparam logic [2:0] INSEL_AMP1 = 3'h3;
	localparam logic [2:0] INSEL_PLT = 3'h4;
	localparam logic [4:0] SAMPLE_TICKS = 5'h04;
	localparam logic [4:0] CONV_TICKS = 5'h0C;
	localparam logic [4:0] TOTAL_TICKS = SAMPLE_TICKS + CONV_TICKS;

	typedef struct packed {
		logic start;
		logic busy;
		logic power_en;
		logic data_format;
		logic [3:0] ext_chan;
	} adcc_ctrl_a_t;

	typedef struct packed {
		logic [2:0] in_sel;
		logic [1:0] ref_sel;
		logic [2:0] clk_div;
	} adcc_ctrl_b_t;

	typedef struct packed {
		logic power_en;
		logic ref_supply;
		logic sample;
		logic convert;
		logic conv_tick;
		logic [NUM_CH-1:0] ext_chan_en;
		logic [NUM_INT-1:0] int_src_en;
	} adcc_core_ctl_t;

	typedef struct packed {
		logic [NUM_CH-1:0] oe;
		logic [NUM_CH-1:0] pull_en;
		logic [NUM_CH-1:0] dig_in_en;
	} adcc_pad_ctl_t;
endpackage : adcc_pkg

// [adcc_core_model.sv]
/*
 * Behavioural model of the analog sample-and-convert core and its input mux.
 * Assumes the control block drives core_ctl on the same clock.
 */
`timescale 1ns/1ps
module adcc_core_model (
	// Clock.
	input wire logic core_clk,
	// Control from the block.
	input wire adcc_pkg::adcc_core_ctl_t core_ctl,
	// Result to the block.
	output logic [adcc_pkg::RES_W-1:0] core_result
);
	import adcc_pkg::*;
	logic [RES_W-1:0] res_reg = 12'h000;
	assign core_result = res_reg;
	always @(posedge core_clk) begin
		if (!core_ctl.power_en) begin
			res_reg <= ~res_reg;
		end else if (|core_ctl.ext_chan_en) begin
			res_reg <= {4'hA, core_ctl.ext_chan_en};
		end else if (|core_ctl.int_src_en) begin
			res_reg <= {8'h50, core_ctl.int_src_en};
		end else begin
			res_reg <= res_reg + 12'h003;
		end
	end
endmodule : adcc_core_model

// [adcc_top_tb_top.sv]
/*
 * Self-checking testbench for the conversion control block.
 * Assumes the package, the design and the core model are compiled first.
 */
`timescale 1ns/1ps
module adcc_top_tb_top;
	import adcc_pkg::*;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic [RES_W-1:0] core_result;
	adcc_core_ctl_t core_ctl;
	logic [NUM_CH-1:0] gpio_oe = 8'hFF;
	logic [NUM_CH-1:0] gpio_pull_en = 8'hF0;
	adcc_pad_ctl_t pad_ctl;
	logic conv_irq_req;
	int n_errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	int ticks = 0;
	logic [7:0] d;
	always #12.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (core_ctl.conv_tick === 1'b1) ticks++;
	end
	adcc_top u_dut (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_result(core_result),
		.core_ctl(core_ctl), .gpio_oe(gpio_oe), .gpio_pull_en(gpio_pull_en), .pad_ctl(pad_ctl),
		.conv_irq_req(conv_irq_req));
	adcc_core_model u_core (.core_clk(core_clk), .core_ctl(core_ctl), .core_result(core_result));
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		chk("register", {8'h00, e}, {8'h00, d});
	endtask : rchk
	task automatic wait_irq(input int lim, output int n);
		n = 0;
		while (conv_irq_req !== 1'b1 && n < lim) begin
			@(posedge core_clk);
			#1 n++;
		end
	endtask : wait_irq
	task automatic conv(input logic [2:0] dv, input logic fm);
		int n;
		wr(OFS_CTRL_B, {5'h00, dv});
		ticks = 0;
		wr(OFS_CTRL_A, {3'h5, fm, 4'h3});
		wr(OFS_CTRL_A, {3'h1, fm, 4'h3});
		wait_irq(3000, n);
		chk("busy length", 16'((16 << dv) + 1), 16'(n));
		chk("tick count", 16'd16, 16'(ticks));
		@(posedge core_clk);
		#1 chk("irq pulse", 16'h0000, {15'h0000, conv_irq_req});
		rchk(OFS_CTRL_A, {3'h1, fm, 4'h3});
		rchk(OFS_RES_HI, fm ? 8'h0A : 8'hA0);
		rchk(OFS_RES_LO, fm ? 8'h08 : 8'h80);
	endtask : conv
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			wrap_up();
		end
	end
	initial begin
		int n;
		repeat (10) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		for (int a = 0; a < 8; a++) rchk(3'(a), 8'h00);
		wr(3'h5, 8'hFF);
		rchk(3'h5, 8'h00);
		wr(OFS_CTRL_A, 8'h4A);
		rchk(OFS_CTRL_A, 8'h0A);
		wr(OFS_CTRL_A, 8'h83);
		wr(OFS_CTRL_A, 8'h03);
		wait_irq(40, n);
		chk("unpowered start", 16'd40, 16'(n));
		rchk(OFS_CTRL_A, 8'h03);
		wr(OFS_CTRL_A, 8'h23);
		repeat (10) @(posedge core_clk);
		for (int v = 0; v < 8; v++) conv(3'(v), v[0]);
		wr(OFS_CTRL_B, 8'h00);
		wr(OFS_CTRL_A, 8'hA3);
		wr(OFS_CTRL_A, 8'h23);
		rchk(OFS_CTRL_A, 8'h63);
		wr(OFS_CTRL_A, 8'h03);
		rchk(OFS_CTRL_A, 8'h03);
		wait_irq(40, n);
		chk("aborted irq", 16'd40, 16'(n));
		rchk(OFS_RES_HI, 8'hA0);
		wr(OFS_CTRL_A, 8'h28);
		wr(OFS_CTRL_B, 8'h20);
		repeat (10) @(posedge core_clk);
		wr(OFS_CTRL_A, 8'hA8);
		wr(OFS_CTRL_A, 8'h28);
		wr(OFS_CTRL_A, 8'hA8);
		rchk(OFS_CTRL_A, 8'hA8);
		wr(OFS_CTRL_A, 8'h28);
		wait_irq(40, n);
		chk("internal busy length", 16'd17, 16'(n));
		rchk(OFS_RES_HI, 8'h50);
		rchk(OFS_RES_LO, 8'h10);
		for (int r = 0; r < 4; r++) begin
			wr(OFS_CTRL_B, {3'h0, 2'(r), 3'h0});
			#1 chk("ref supply", 16'(r == 1), {15'h0000, core_ctl.ref_supply});
		end
		for (int c = 0; c < 16; c++) for (int s = 0; s < 8; s++) if (c > 7 || s == 0 || s > 4) begin
			wr(OFS_CTRL_B, 8'h00);
			wr(OFS_CTRL_A, {4'h2, 4'(c)});
			wr(OFS_CTRL_B, {3'(s), 5'h00});
			#1 chk("ext select", 16'(c < 8 ? 1 << c : 0), 16'(core_ctl.ext_chan_en));
			chk("int select", 16'(c > 7 && s > 0 && s < 5 ? 1 << (s - 1) : 0), 16'(core_ctl.int_src_en));
		end
		wr(OFS_PIN_SEL, 8'h5A);
		#1 chk("pad oe", 16'h00A5, 16'(pad_ctl.oe));
		chk("pad pull", 16'h00A0, 16'(pad_ctl.pull_en));
		chk("pad digital in", 16'h00A5, 16'(pad_ctl.dig_in_en));
		rchk(OFS_PIN_SEL, 8'h5A);
		wr(OFS_CTRL_A, 8'h00);
		#1 chk("power off", 16'h0000, {15'h0000, core_ctl.power_en});
		wrap_up();
	end
endmodule : adcc_top_tb_top
